/* pkg/twe_consts.svh */
// timing counts and field positions for the two-wire memory host
`ifndef TWE_CONSTS_SVH
`define TWE_CONSTS_SVH

// system clock and serial clock rates in kHz
`define TWE_CLK_KHZ 50000
`define TWE_SCL_KHZ 100
// quarter of a serial clock period in system cycles, rounded up
`define TWE_QTR_CYC ((`TWE_CLK_KHZ + 4 * `TWE_SCL_KHZ - 1) / (4 * `TWE_SCL_KHZ))
// longest internal write duration in ms and in system cycles
`define TWE_WR_MS 10
`define TWE_WR_CYC (`TWE_WR_MS * `TWE_CLK_KHZ)
// index of the acknowledge slot within a nine-bit word
`define TWE_ACK_BIT 4'h8
// bit index of the last data bit before the acknowledge slot
`define TWE_LSB_BIT 4'h7
// reset level of the serial clock pin
`define TWE_SCL_RST 1'b1

`endif

/* pkg/twe_pkg.sv */
// types shared by the two-wire memory host
package twe_pkg;

   // operations the host can run
   typedef enum logic [1:0]
   {
      OP_WRITE   = 2'h0,
      OP_READ    = 2'h1,
      OP_RECOVER = 2'h2
   } twe_op_t;

   // one command: operation, 7-bit word address, byte count minus one
   typedef struct packed
   {
      twe_op_t    op;
      logic [6:0] addr;
      logic [6:0] len_m1;
   } twe_cmd_t;

   // host sequencer states
   typedef enum logic [2:0]
   {
      ST_IDLE  = 3'h0,
      ST_START = 3'h1,
      ST_XFER  = 3'h2,
      ST_LOAD  = 3'h3,
      ST_STOP  = 3'h4,
      ST_RECOV = 3'h5
   } twe_state_t;

endpackage

/* design/twe_host.sv */
// host controller driving a two-wire serial memory over its clock and data pins
// Notes on behaviour
// - data changes only while clock low
// - start is data falling, clock high
// - stop is data rising, clock high
// - receiver pulls data low in ninth clock
// - recovery: up to nine clocks, then start
// - byte write: address, write bit, one byte
// - stop after last byte starts internal write
// - page write sends up to 128 bytes
// - poll with address word until acknowledged; host stops with an error once its write timer is zero
// - byte read: address, read bit, eight bits
// - last read byte unacknowledged, then stop
// - host acknowledges each non-final read byte
// - no acknowledge plus stop ends read
`timescale 1ns/100ps
`include "twe_consts.svh"
module twe_host
   import twe_pkg::*;
#(
   parameter int unsigned WR_CYC = `TWE_WR_CYC
)
(
   // clock and reset
   input  logic       i_clk,
   input  logic       i_rst,
   // command port
   input  logic       i_cmd_valid,
   input  twe_cmd_t   i_cmd,
   output logic       o_busy,
   output logic       o_done,
   output logic       o_err,
   // write data stream
   input  logic [7:0] i_wdata,
   input  logic       i_wvalid,
   output logic       o_wready,
   // read data stream
   output logic [7:0] o_rdata,
   output logic       o_rvalid,
   // serial pins
   output logic       o_scl,
   input  logic       i_sda,
   output logic       o_sda_o,
   output logic       o_sda_oe_n
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic       sda_s1_q;
   logic       sda_s2_q;
   twe_state_t st_q;
   twe_state_t nxt_word;
   logic [1:0] ph_q;
   logic [6:0] qcnt_q;
   logic [3:0] bit_q;
   logic [7:0] sh_q;
   logic       rx_q;
   logic       first_q;
   logic       acked_q;
   logic       retry_q;
   logic       err_q;
   logic       wpend_q;
   logic       rdok_q;
   twe_op_t    op_q;
   logic [6:0] addr_q;
   logic [6:0] left_q;
   logic [18:0] wt_q;
   logic       busy_q;
   logic       wreq_q;
   logic       done_q;
   logic       errp_q;
   logic       rvalid_q;
   logic [7:0] rdata_q;
   logic       scl_q;
   logic       scl_d;
   logic       sda_oe_n_q;
   logic       sda_oe_n_d;
   logic       sda_o_q;
   logic       tick;
   logic       ph_end;
   logic       smp;

   // ----------------------------------------------------------------
   // pin synchroniser and quarter-period timing
   // ----------------------------------------------------------------
   // two stages before any logic sees the data pin
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
      end
      else
      begin
         sda_s1_q <= i_sda;
         sda_s2_q <= sda_s1_q;
      end
   end

   assign tick   = (qcnt_q == 7'(`TWE_QTR_CYC - 1));
   assign ph_end = tick && (ph_q == 2'h3);
   // sampling point: end of the first high quarter
   assign smp    = tick && (ph_q == 2'h1);

   // quarter counter, held while idle or waiting for data
   always_ff @(posedge i_clk)
   begin
      if (i_rst || st_q == ST_IDLE || st_q == ST_LOAD || tick)
         qcnt_q <= 7'h00;
      else
         qcnt_q <= qcnt_q + 7'h01;
   end

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   // what follows the acknowledge slot of a word
   always_comb
   begin
      nxt_word = ST_STOP;
      if (rx_q)
         nxt_word = (left_q == 7'h00) ? ST_STOP : ST_XFER;
      else if (!acked_q)
         nxt_word = ST_STOP;
      else if (first_q)
         nxt_word = (op_q == OP_READ) ? ST_XFER : ST_LOAD;
      else
         nxt_word = (left_q == 7'h00) ? ST_STOP : ST_LOAD;
   end

   // state, phase and bit position
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         st_q  <= ST_IDLE;
         ph_q  <= 2'h0;
         bit_q <= 4'h0;
      end
      else
      begin
         if (tick && st_q != ST_IDLE && st_q != ST_LOAD)
            ph_q <= ph_q + 2'h1;
         case (st_q)
            ST_IDLE:
               if (i_cmd_valid)
               begin
                  ph_q  <= 2'h0;
                  bit_q <= 4'h0;
                  st_q  <= (i_cmd.op == OP_RECOVER) ? ST_RECOV : ST_START;
               end
            ST_START:
               if (ph_end)
               begin
                  bit_q <= 4'h0;
                  st_q  <= (op_q == OP_RECOVER) ? ST_STOP : ST_XFER;
               end
            ST_XFER:
               if (ph_end)
               begin
                  if (bit_q != `TWE_ACK_BIT)
                     bit_q <= bit_q + 4'h1;
                  else
                  begin
                     bit_q <= 4'h0;
                     st_q  <= nxt_word;
                  end
               end
            ST_LOAD:
               if (wreq_q && i_wvalid)
                  st_q <= ST_XFER;
            ST_STOP:
               if (ph_end)
                  st_q <= retry_q ? ST_START : ST_IDLE;
            ST_RECOV:
               if (ph_end)
               begin
                  if (rdok_q || bit_q == `TWE_ACK_BIT)
                  begin
                     bit_q <= 4'h0;
                     st_q  <= ST_START;
                  end
                  else
                     bit_q <= bit_q + 4'h1;
               end
            default:
               st_q <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // word shifter and transfer bookkeeping
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         sh_q     <= 8'h00;
         rx_q     <= 1'b0;
         first_q  <= 1'b0;
         acked_q  <= 1'b0;
         retry_q  <= 1'b0;
         err_q    <= 1'b0;
         wpend_q  <= 1'b0;
         rdok_q   <= 1'b0;
         op_q     <= OP_WRITE;
         addr_q   <= 7'h00;
         left_q   <= 7'h00;
         wreq_q   <= 1'b0;
         rdata_q  <= 8'h00;
         rvalid_q <= 1'b0;
      end
      else
      begin
         rvalid_q <= 1'b0;
         case (st_q)
            ST_IDLE:
               if (i_cmd_valid)
               begin
                  op_q    <= i_cmd.op;
                  addr_q  <= i_cmd.addr;
                  left_q  <= i_cmd.len_m1;
                  retry_q <= 1'b0;
                  err_q   <= 1'b0;
                  wpend_q <= 1'b0;
                  rdok_q  <= 1'b0;
               end
            ST_START:
               if (ph_end)
               begin
                  sh_q    <= {addr_q, op_q == OP_READ};
                  rx_q    <= 1'b0;
                  first_q <= 1'b1;
                  retry_q <= 1'b0;
               end
            ST_XFER:
            begin
               if (smp && bit_q == `TWE_ACK_BIT)
                  acked_q <= !sda_s2_q;
               else if (smp && rx_q)
                  sh_q <= {sh_q[6:0], sda_s2_q};
               if (ph_end && bit_q != `TWE_ACK_BIT && !rx_q)
                  sh_q <= {sh_q[6:0], 1'b0};
               if (ph_end && bit_q == `TWE_ACK_BIT)
               begin
                  first_q <= 1'b0;
                  if (rx_q)
                  begin
                     rdata_q  <= sh_q;
                     rvalid_q <= 1'b1;
                     if (left_q != 7'h00)
                        left_q <= left_q - 7'h01;
                  end
                  else if (!acked_q)
                  begin
                     retry_q <= first_q && (wt_q != 19'h00000);
                     err_q   <= !(first_q && (wt_q != 19'h00000));
                  end
                  else if (first_q)
                  begin
                     rx_q   <= (op_q == OP_READ);
                     wreq_q <= (op_q != OP_READ);
                  end
                  else if (left_q != 7'h00)
                  begin
                     left_q <= left_q - 7'h01;
                     wreq_q <= 1'b1;
                  end
                  else
                     wpend_q <= 1'b1;
               end
            end
            ST_LOAD:
               if (wreq_q && i_wvalid)
               begin
                  sh_q   <= i_wdata;
                  wreq_q <= 1'b0;
               end
            ST_RECOV:
               if (smp && sda_s2_q)
                  rdok_q <= 1'b1;
            default:
               wreq_q <= wreq_q;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // internal write timer and command status
   // ----------------------------------------------------------------
   // timer runs from the stop
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         wt_q <= 19'h00000;
      else if (st_q == ST_STOP && ph_end && wpend_q)
         wt_q <= 19'(WR_CYC);
      else if (wt_q != 19'h00000)
         wt_q <= wt_q - 19'h00001;
   end

   // busy level, done pulse and error flag
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         busy_q <= 1'b0;
         done_q <= 1'b0;
         errp_q <= 1'b0;
      end
      else
      begin
         done_q <= 1'b0;
         if (st_q == ST_IDLE && i_cmd_valid)
         begin
            busy_q <= 1'b1;
            errp_q <= 1'b0;
         end
         else if (st_q == ST_STOP && ph_end && !retry_q)
         begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
            errp_q <= err_q || (op_q == OP_RECOVER && !rdok_q);
         end
      end
   end

   // ----------------------------------------------------------------
   // pin drive
   // ----------------------------------------------------------------
   // clock and data levels for the current state and phase
   always_comb
   begin
      scl_d      = scl_q;
      sda_oe_n_d = sda_oe_n_q;
      case (st_q)
         ST_IDLE:
         begin
            scl_d      = 1'b1;
            sda_oe_n_d = 1'b1;
         end
         ST_START:
         begin
            scl_d      = (ph_q != 2'h3);
            sda_oe_n_d = (ph_q == 2'h0);
         end
         ST_XFER:
         begin
            scl_d = (ph_q == 2'h1) || (ph_q == 2'h2);
            if (ph_q == 2'h0)
            begin
               if (bit_q != `TWE_ACK_BIT)
                  sda_oe_n_d = rx_q || sh_q[7];
               else
                  sda_oe_n_d = !rx_q || (left_q == 7'h00);
            end
         end
         ST_LOAD:
            scl_d = 1'b0;
         ST_STOP:
         begin
            scl_d      = (ph_q != 2'h0);
            sda_oe_n_d = ph_q[1];
         end
         ST_RECOV:
         begin
            scl_d      = (ph_q == 2'h1) || (ph_q == 2'h2);
            sda_oe_n_d = 1'b1;
         end
         default:
         begin
            scl_d      = 1'b1;
            sda_oe_n_d = 1'b1;
         end
      endcase
   end

   // data pin only ever pulled low
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         scl_q      <= `TWE_SCL_RST;
         sda_oe_n_q <= 1'b1;
         sda_o_q    <= 1'b0;
      end
      else
      begin
         scl_q      <= scl_d;
         sda_oe_n_q <= sda_oe_n_d;
         sda_o_q    <= 1'b0;
      end
   end

   // outputs straight from flip-flops
   assign o_busy     = busy_q;
   assign o_done     = done_q;
   assign o_err      = errp_q;
   assign o_wready   = wreq_q;
   assign o_rdata    = rdata_q;
   assign o_rvalid   = rvalid_q;
   assign o_scl      = scl_q;
   assign o_sda_o    = sda_o_q;
   assign o_sda_oe_n = sda_oe_n_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   a_sda_quiet_high: assert property (st_q == ST_XFER && $past(st_q) == ST_XFER && scl_q && $past(scl_q)
      |-> $stable(sda_oe_n_q)) else $error("data moved while clock high");
   a_start_form: assert property ($fell(sda_oe_n_q) && scl_q && $past(scl_q)
      |-> $past(st_q) == ST_START) else $error("data fell with clock high outside start");
   a_stop_form: assert property ($rose(sda_oe_n_q) && scl_q && $past(scl_q)
      |-> $past(st_q) == ST_STOP) else $error("data rose with clock high outside stop");
   a_ack_slot_free: assert property (st_q == ST_XFER && !rx_q && bit_q == `TWE_ACK_BIT && ph_q != 2'h0
      |-> sda_oe_n_q) else $error("host drove data in memory acknowledge slot");
   a_read_ack_low: assert property (st_q == ST_XFER && rx_q && bit_q == `TWE_ACK_BIT && smp
      && left_q != 7'h00 |-> !sda_oe_n_q) else $error("read byte not acknowledged");
   a_last_nack_stop: assert property (st_q == ST_XFER && rx_q && bit_q == `TWE_ACK_BIT && smp
      && left_q == 7'h00 |-> sda_oe_n_q ##[1:600] st_q == ST_STOP)
      else $error("last read byte not ended by nack and stop");
   a_rw_select: assert property (st_q == ST_XFER && first_q && bit_q == `TWE_LSB_BIT && ph_q == 2'h2
      |-> sda_oe_n_q == (op_q == OP_READ)) else $error("read select bit wrong");
   a_msb_order: assert property (st_q == ST_XFER && !rx_q && bit_q != `TWE_ACK_BIT && ph_q == 2'h2
      |-> sda_oe_n_q == sh_q[7]) else $error("sent bit is not the word msb");
   a_poll_retry: assert property (st_q == ST_XFER && first_q && bit_q == `TWE_ACK_BIT && smp && sda_s2_q
      && wt_q > 19'd300 |-> ##[1:1000] st_q == ST_START) else $error("nack during write not polled again");
   a_write_stop: assert property (st_q == ST_XFER && !rx_q && !first_q && bit_q == `TWE_ACK_BIT && ph_end
      && acked_q && left_q == 7'h00 |=> st_q == ST_STOP ##[1:600] wt_q == 19'(WR_CYC))
      else $error("write not closed by stop and timer");
   a_page_nostop: assert property (st_q == ST_XFER && !rx_q && !first_q && bit_q == `TWE_ACK_BIT && ph_end
      && acked_q && left_q != 7'h00 |=> st_q == ST_LOAD) else $error("page write stopped early");
   a_recov_start: assert property (st_q == ST_RECOV && smp && sda_s2_q
      |-> ##[1:300] st_q == ST_START) else $error("recovery did not end in start");

   c_write_done: cover property (done_q && op_q == OP_WRITE && !errp_q);
   c_seq_read: cover property (rvalid_q && left_q != 7'h00);
   c_poll: cover property (st_q == ST_STOP ##1 st_q == ST_START);
   c_recover: cover property (done_q && op_q == OP_RECOVER);

endmodule

/* tb/twe_mem_model.sv */
// behavioural two-wire serial memory that answers the host
`timescale 1ns/100ps
module twe_mem_model
#(
   parameter int unsigned WR_NS = 150000 // internal write duration in ns
)
(
   // serial pins
   input  wire logic i_scl,
   input  wire logic i_sda,
   output logic      o_pull_low
);
   // ----------
   // state
   // ----------
   // array of 128 bytes
   logic [7:0] mem_q [128];
   logic [7:0] shift_q;
   logic [6:0] ptr_q;
   int         nbit_q;
   bit         active_q, first_q, rd_q, dirty_q, wbusy_q;

   initial
   begin
      o_pull_low = 1'b0;
      for (int i = 0; i < 128; i++)
         mem_q[i] = 8'(i * 29) ^ 8'h5A;
   end

   // start opens a command unless writing
   always @(negedge i_sda)
   begin
      if (i_scl === 1'b1 && !wbusy_q)
      begin
         active_q = 1'b1;
         first_q  = 1'b1;
         nbit_q   = 0;
      end
   end

   // stop ends transfer and launches write
   // a stop during the write is ignored like any other input
   always @(posedge i_sda)
   begin
      if (i_scl === 1'b1 && !wbusy_q)
      begin
         active_q   = 1'b0;
         o_pull_low = 1'b0;
         wbusy_q    = dirty_q;
         dirty_q    = 1'b0;
      end
   end

   always @(posedge wbusy_q)
   begin
      #(WR_NS);
      wbusy_q = 1'b0;
   end

   // sample msb first on rising clock
   always @(posedge i_scl)
   begin
      if (active_q && !wbusy_q && nbit_q < 8)
      begin
         shift_q = {shift_q[6:0], i_sda};
         nbit_q++;
      end
      else if (active_q && !wbusy_q)
      begin
         nbit_q = 0;
         if (first_q)
         begin
            ptr_q   = shift_q[7:1];
            rd_q    = shift_q[0];
            first_q = 1'b0;
         end
         else if (!rd_q)
         begin
            mem_q[ptr_q]  = shift_q;
            ptr_q[1:0]    = ptr_q[1:0] + 2'h1;
            dirty_q       = 1'b1;
         end
         else if (i_sda)
            active_q = 1'b0;
         // next address wraps over the array
         else
            ptr_q = ptr_q + 7'h01;
      end
   end

   // pull low only, after falling clock
   always @(negedge i_scl)
   begin
      if (!active_q || wbusy_q)
         o_pull_low = 1'b0;
      else if (nbit_q == 8)
         o_pull_low = first_q || !rd_q;
      else if (rd_q && !first_q)
         o_pull_low = !mem_q[ptr_q][7 - nbit_q];
      else
         o_pull_low = 1'b0;
   end
endmodule

/* tb/tb.sv */
// bench for the two-wire memory host against a behavioural memory
`timescale 1ns/100ps
module tb
   import twe_pkg::*;
;
   // ----------
   // signals
   // ----------
   localparam int unsigned WR_CYC  = 12000;
   localparam int          TIMEOUT = 95000;
   logic       i_clk, i_rst, i_cmd_valid, i_wvalid;
   twe_cmd_t   i_cmd;
   logic [7:0] i_wdata, o_rdata;
   logic       o_busy, o_done, o_err, o_wready, o_rvalid;
   logic       o_scl, o_sda_o, o_sda_oe_n, pull_low, err;
   logic [6:0] a;
   logic [7:0] wd[$], rd[$];
   logic [7:0] shadow [128];
   int         n_mismatch = 0, checks_done = 0, cycles = 0, n_start = 0;
   wire        sda_line;

   // wired-and data line with pull-up
   assign sda_line = (o_sda_oe_n ? 1'b1 : o_sda_o) & ~pull_low;

   twe_host #(.WR_CYC(WR_CYC)) dut (
      .i_clk(i_clk), .i_rst(i_rst), .i_cmd_valid(i_cmd_valid), .i_cmd(i_cmd),
      .o_busy(o_busy), .o_done(o_done), .o_err(o_err), .i_wdata(i_wdata),
      .i_wvalid(i_wvalid), .o_wready(o_wready), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
      .o_scl(o_scl), .i_sda(sda_line), .o_sda_o(o_sda_o), .o_sda_oe_n(o_sda_oe_n));

   twe_mem_model mem (.i_scl(o_scl), .i_sda(sda_line), .o_pull_low(pull_low));

   // ----------
   // helpers
   // ----------
   function automatic logic [7:0] seed_byte(input int n);
      return 8'(n * 29) ^ 8'h5A;
   endfunction

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      if (n_mismatch == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // one command, feeding wd and collecting rd until done
   task automatic run_cmd(input twe_op_t op, input logic [6:0] ad, input int n);
      int k;
      k = 0;
      rd = {};
      @(posedge i_clk);
      #1;
      i_cmd.op     = op;
      i_cmd.addr   = ad;
      i_cmd.len_m1 = 7'(n - 1);
      i_cmd_valid  = 1'b1;
      forever
      begin
         @(posedge i_clk);
         if (o_wready && i_wvalid)
            k++;
         if (o_rvalid)
            rd.push_back(o_rdata);
         if (o_done)
            break;
         #1;
         i_cmd_valid = 1'b0;
         i_wvalid    = (op == OP_WRITE) && (k < wd.size());
         i_wdata     = (k < wd.size()) ? wd[k] : 8'h00;
      end
      err = o_err;
      check({7'h00, o_busy}, 8'h00);
      if (op == OP_WRITE)
         check(8'(k), 8'(n));
      check({7'h00, sda_line}, 8'h01);
      check({7'h00, o_scl}, 8'h01);
      check({7'h00, o_sda_o}, 8'h00);
   endtask

   // ----------
   // clock, watchdog, wire monitor
   // ----------
   initial
   begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end

   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == TIMEOUT)
      begin
         n_mismatch++;
         close_out();
      end
   end

   // count start conditions on the wire
   always @(negedge sda_line)
      if (o_scl === 1'b1)
         n_start++;

   // ----------
   // scenarios
   // ----------
   initial
   begin
      i_rst       = 1'b1;
      i_cmd_valid = 1'b0;
      i_cmd       = '0;
      i_wdata     = 8'h00;
      i_wvalid    = 1'b0;
      void'($urandom(32'h86EA));
      for (int i = 0; i < 128; i++)
         shadow[i] = seed_byte(i);
      repeat (2) @(posedge i_clk);
      #1 i_rst = 1'b0;
      // bus recovery on an idle line
      run_cmd(OP_RECOVER, 7'h00, 1);
      check({7'h00, err}, 8'h00);
      check(8'(n_start), 8'h01);
      // page write crossing the page end
      wd = {};
      repeat (3) wd.push_back(8'($urandom));
      run_cmd(OP_WRITE, 7'h7E, 3);
      check({7'h00, err}, 8'h00);
      a = 7'h7E;
      foreach (wd[i])
      begin
         shadow[a]  = wd[i];
         a[1:0]     = a[1:0] + 2'h1;
      end
      // sequential read at once, polling while the write runs
      run_cmd(OP_READ, 7'h7C, 5);
      check({7'h00, err}, 8'h00);
      check(8'(rd.size()), 8'h05);
      for (int i = 0; i < 5; i++)
         check(rd[i], shadow[7'(7'h7C + i)]);
      check(rd[4], shadow[0]);
      // random byte write then byte read
      a  = 7'($urandom_range(0, 127));
      wd = {8'($urandom)};
      run_cmd(OP_WRITE, a, 1);
      check({7'h00, err}, 8'h00);
      shadow[a] = wd[0];
      run_cmd(OP_READ, a, 1);
      check({7'h00, err}, 8'h00);
      check(8'(rd.size()), 8'h01);
      check(rd[0], shadow[a]);
      close_out();
   end
endmodule
